/* File: include/sar_adc_defs.svh */
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH
// register byte offsets on the bus
`define OFF_CONTROL 12'h000
`define OFF_RESULT 12'h004
`define OFF_FLAGS 12'h008
`define OFF_IRQ_EN 12'h00C
`define OFF_SLEEP 12'h010
// control register field positions
`define CLKSEL_HI 7
`define CLKSEL_LO 5
`define CHSEL_HI 4
`define CHSEL_LO 2
`define GO_BIT 1
`define EN_BIT 0
`define CONTROL_RESET 8'h00
// half-period counts make 9.5 periods exact: 19 half periods per conversion
`define HALF_PERIODS 5'h13
`define RESULT_BITS 8
`endif

/* File: include/sar_adc_pkg.sv */
`default_nettype none
package sar_adc_pkg;
    // conversion engine states
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} conv_state_t;
    // analog source choices routed to the sample-and-hold
    typedef enum logic [2:0] {
        SRC_PIN0, SRC_PIN1, SRC_PIN2, SRC_NONE, SRC_TEMP, SRC_FIXREF
    } analog_src_t;
    // control register layout
    typedef struct packed {
        logic [2:0] clk_sel;
        logic [2:0] ch_sel;
        logic go;
        logic enable;
    } control_t;
    // analog front-end handshake
    typedef struct packed {
        logic sample;
        logic [7:0] trial;
        logic powered;
    } afe_ctrl_t;
endpackage
`default_nettype wire

/* File: src/sar_adc_sequencer.sv */
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`include "sar_adc_defs.svh"
`default_nettype none
module sar_adc_sequencer #(
    parameter int INSTR_CYCLES = 4 // system clocks per instruction cycle
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic rc_clk_tick, // one-cycle pulse per rc half period
    input wire logic sleep_req, // core is in sleep
    input wire logic comparator_hi, // comparator: input above trial value
    output sar_adc_pkg::afe_ctrl_t afe,
    output sar_adc_pkg::analog_src_t analog_src,
    output logic use_supply_ref,
    output logic irq,
    output logic wake,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import sar_adc_pkg::*;
    // the delay counter is eight bits wide, so larger instruction lengths cannot be served
    if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255) begin : g_bad_instr
        $error("INSTR_CYCLES out of range");
    end

    // software-visible state
    control_t ctrl_q;
    logic done_flag_q; // sticky completion flag
    logic irq_en_q; // completion interrupt enable
    logic [7:0] result_q; // last stored result
    logic powered_q; // analog core powered
    // engine state
    conv_state_t state_q;
    logic [4:0] half_q; // half periods elapsed in conversion
    logic [6:0] div_q; // system clock divider
    logic [7:0] delay_q; // instruction delay counter for rc start
    logic [7:0] sar_q; // successive approximation register
    logic [2:0] bit_q; // bit under trial
    logic resolved_q; // at least one bit resolved
    logic last_bit_q; // value of last resolved bit
    // bus write capture
    logic [11:0] aw_q;
    logic aw_have_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic w_have_q;

    // divider half period in system clocks for each system-derived selection
    function automatic logic [6:0] half_div(input logic [2:0] sel);
        case (sel)
            3'h0: half_div = 7'h01; // /2
            3'h4: half_div = 7'h02; // /4
            3'h1: half_div = 7'h04; // /8
            3'h5: half_div = 7'h08; // /16
            3'h2: half_div = 7'h10; // /32
            3'h6: half_div = 7'h20; // /64
            default: half_div = 7'h01;
        endcase
    endfunction

    // fill unresolved bits with the last resolved bit
    function automatic logic [7:0] fill_partial(input logic [7:0] v, input logic [2:0] b,
                                                input logic lb);
        logic [7:0] m;
        m = 8'hFF >> (3'h7 - b); // bits b..0 unresolved
        fill_partial = (v & ~m) | (lb ? m : 8'h00);
    endfunction

    // decode and engine combinational terms
    wire use_rc = (ctrl_q.clk_sel[1:0] == 2'h3);
    wire div_tick = (div_q == 7'h01);
    wire half_tick = use_rc ? rc_clk_tick : div_tick;
    wire busy = (state_q != ST_IDLE);
    wire conv_done = (state_q == ST_CONV) && half_tick && (half_q == `HALF_PERIODS - 5'h01);
    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire ctrl_wr = do_write && (aw_q == `OFF_CONTROL) && ws_q[0];
    wire flag_wr = do_write && (aw_q == `OFF_FLAGS) && ws_q[0];
    wire ien_wr = do_write && (aw_q == `OFF_IRQ_EN) && ws_q[0];
    wire sw_abort = ctrl_wr && !w_q[`GO_BIT] && busy;
    // start only when enable already set before this write
    wire start = ctrl_wr && w_q[`GO_BIT] && ctrl_q.enable && !busy;
    wire sleep_abort = busy && sleep_req && !use_rc;
    // a trial bit resolves at each odd half period after the three sample half periods
    wire resolve = (state_q == ST_CONV) && half_tick && half_q[0] && (half_q >= 5'h03);
    wire [7:0] trial = sar_q | (8'h01 << bit_q);

    // sources, reference and analog handshake
    assign analog_src = (ctrl_q.ch_sel == 3'h0) ? SRC_PIN0 :
                        (ctrl_q.ch_sel == 3'h1) ? SRC_PIN1 :
                        (ctrl_q.ch_sel == 3'h2) ? SRC_PIN2 :
                        (ctrl_q.ch_sel == 3'h6) ? SRC_TEMP :
                        (ctrl_q.ch_sel == 3'h7) ? SRC_FIXREF : SRC_NONE;
    assign use_supply_ref = 1'b1;
    assign afe.sample = (state_q == ST_CONV) && (half_q < 5'h03);
    assign afe.trial = trial;
    assign afe.powered = powered_q;
    assign irq = done_flag_q && irq_en_q;
    assign wake = irq && sleep_req;

    // control register, go bit handling
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_q <= `CONTROL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= w_q[7:0];
            // go never survives a write that drops the enable
            ctrl_q.go <= w_q[`GO_BIT] && w_q[`EN_BIT] && ctrl_q.enable
                         && (busy || !sleep_req || use_rc);
        end else if (conv_done || sleep_abort) begin
            ctrl_q.go <= 1'b0;
        end
    end

    // done flag: hardware set wins over software clear
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            done_flag_q <= 1'b0;
        end else if (conv_done) begin
            done_flag_q <= 1'b1;
        end else if (flag_wr && !w_q[0]) begin
            done_flag_q <= 1'b0;
        end
    end

    // interrupt enable
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_en_q <= 1'b0;
        end else if (ien_wr) begin
            irq_en_q <= w_q[0];
        end
    end

    // result: only completion or software abort loads it
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            result_q <= 8'h00;
        end else if (conv_done) begin
            result_q <= sar_q; // all eight bits resolved by now
        end else if (sw_abort && state_q == ST_CONV) begin
            result_q <= resolved_q ? fill_partial(sar_q, bit_q, last_bit_q) : 8'h00;
        end
    end
    // analog power: follows enable, dropped by sleep cases
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            powered_q <= 1'b0;
        end else if (sleep_abort) begin
            powered_q <= 1'b0;
        end else if (sleep_req && !irq_en_q && (conv_done || !busy)) begin
            powered_q <= 1'b0; // off once the conversion in sleep ends
        end else if (!sleep_req) begin
            powered_q <= ctrl_q.enable;
        end
    end

    // conversion clock divider
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !busy || div_tick) begin
            div_q <= reset_n ? half_div(ctrl_q.clk_sel) : 7'h01;
        end else begin
            div_q <= div_q - 7'h01;
        end
    end

    // conversion engine
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            half_q <= 5'h00;
            delay_q <= 8'h00;
            sar_q <= 8'h00;
            bit_q <= 3'h7;
            resolved_q <= 1'b0;
            last_bit_q <= 1'b0;
        end else if (sw_abort || sleep_abort || !ctrl_q.enable) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= use_rc ? ST_DELAY : ST_CONV;
                        delay_q <= INSTR_CYCLES[7:0];
                        half_q <= 5'h00;
                        sar_q <= 8'h00;
                        bit_q <= 3'h7;
                        resolved_q <= 1'b0;
                    end
                end
                ST_DELAY: begin
                    delay_q <= delay_q - 8'h01;
                    if (delay_q == 8'h01) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (half_tick) begin
                        half_q <= half_q + 5'h01;
                    end
                    if (resolve) begin
                        sar_q <= comparator_hi ? trial : sar_q;
                        last_bit_q <= comparator_hi;
                        resolved_q <= 1'b1;
                        bit_q <= bit_q - 3'h1;
                    end
                    if (conv_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // axi write channel capture, either order
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 12'h000;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;
    // read channel: unmapped addresses read zero with okay
    wire [31:0] rd_mux = (s_axi_araddr == `OFF_CONTROL) ? {24'h0, ctrl_q} :
                         (s_axi_araddr == `OFF_RESULT) ? {24'h0, result_q} :
                         (s_axi_araddr == `OFF_FLAGS) ? {31'h0, done_flag_q} :
                         (s_axi_araddr == `OFF_IRQ_EN) ? {31'h0, irq_en_q} :
                         (s_axi_araddr == `OFF_SLEEP) ? {30'h0, powered_q, busy} : 32'h0;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;

    // assertions
    property p_done_sets_flag;
        @(posedge sys_clk) disable iff (!reset_n) conv_done |=> done_flag_q;
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag) else $error("flag not set");
    property p_done_clears_go;
        @(posedge sys_clk) disable iff (!reset_n) conv_done && !ctrl_wr |=> !ctrl_q.go;
    endproperty
    a_done_clears_go: assert property (p_done_clears_go) else $error("go not cleared");
    property p_abort_no_flag;
        @(posedge sys_clk) disable iff (!reset_n)
            sw_abort && !done_flag_q && !conv_done |=> !done_flag_q;
    endproperty
    a_abort_no_flag: assert property (p_abort_no_flag) else $error("abort set flag");
    property p_result_stable;
        @(posedge sys_clk) disable iff (!reset_n)
            !conv_done && !sw_abort |=> $stable(result_q);
    endproperty
    a_result_stable: assert property (p_result_stable) else $error("result moved");
    property p_go_needs_enable;
        @(posedge sys_clk) disable iff (!reset_n) ctrl_q.go |-> ctrl_q.enable || busy;
    endproperty
    a_go_needs_enable: assert property (p_go_needs_enable) else $error("go without enable");
    property p_rc_delay;
        @(posedge sys_clk) disable iff (!reset_n) start && use_rc |=> state_q == ST_DELAY;
    endproperty
    a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");
    property p_sleep_abort;
        @(posedge sys_clk) disable iff (!reset_n)
            sleep_abort |=> state_q == ST_IDLE && !powered_q;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort failed");
    property p_irq;
        @(posedge sys_clk) disable iff (!reset_n) conv_done && irq_en_q && !ien_wr |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
endmodule // sar_adc_sequencer
`default_nettype wire

/* File: sim/tb_sar_adc_sequencer.sv */
`include "sar_adc_defs.svh"
`default_nettype none
module tb_sar_adc_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_adc_pkg::*;
    localparam int INSTR = 20; // long instruction delay so the rc start lag is measurable
    localparam int LIMIT = 30000; // cycle ceiling for the whole run
    logic sys_clk, reset_n, rc_clk_tick, sleep_req, comparator_hi;
    afe_ctrl_t afe;
    analog_src_t analog_src;
    logic use_supply_ref, irq, wake;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_rresp, last_bresp;
    logic [7:0] target; // analog level modelled as target plus half a step
    int cyc, t0, err_count, compares;
    logic [31:0] v;
    sar_adc_sequencer #(.INSTR_CYCLES(INSTR)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .rc_clk_tick(rc_clk_tick), .sleep_req(sleep_req), .comparator_hi(comparator_hi),
        .afe(afe), .analog_src(analog_src), .use_supply_ref(use_supply_ref), .irq(irq),
        .wake(wake), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    // comparator model: half a step above target avoids any tie at the trial code
    assign comparator_hi = (afe.trial <= target);
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // cycle count, rc ticks every five cycles, hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        rc_clk_tick <= (cyc % 5 == 4);
        if (cyc == LIMIT) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // range compare for measured durations
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // axi write: ready sampled at the negedge, which equals its value at the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) last_bresp = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic ta, tr;
        tr = 1'b0;
        d = 32'h0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr) begin
            @(negedge sys_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            if (tr) d = s_axi_rdata;
            if (tr) last_rresp = s_axi_rresp;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask
    function automatic logic [31:0] cw(logic [2:0] cs, logic [2:0] ch, logic go, logic en);
        return {24'h0, cs, ch, go, en};
    endfunction
    // enable first, then go in a later write
    task automatic start(input logic [2:0] cs, input logic [7:0] tg);
        target <= tg;
        wr(`OFF_CONTROL, cw(cs, 3'h0, 1'b0, 1'b1));
        repeat (4) @(posedge sys_clk); // let the hold settle on the channel
        wr(`OFF_CONTROL, cw(cs, 3'h0, 1'b1, 1'b1));
        t0 = cyc;
    endtask
    task automatic wait_irq();
        while (irq !== 1'b1) @(negedge sys_clk);
    endtask
    task automatic poll_go();
        v = 32'h2;
        while (v[1]) rd(`OFF_CONTROL, v);
    endtask
    logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    analog_src_t src_exp [8] = '{SRC_PIN0, SRC_PIN1, SRC_PIN2, SRC_NONE, SRC_NONE, SRC_NONE,
        SRC_TEMP, SRC_FIXREF};
    initial begin
        {sys_clk, reset_n, sleep_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {cyc, err_count, compares, target, last_rresp} = '0;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk(`OFF_CONTROL, 32'h0, "control reset");
        rd_chk(`OFF_FLAGS, 32'h0, "flag reset");
        chk("supply ref", 32'h1, 32'(use_supply_ref));
        $display("test reset done");
        // field layout and channel routing, every code
        for (int i = 0; i < 8; i++) begin
            wr(`OFF_CONTROL, cw(3'(i), 3'(i), 1'b0, 1'b1));
            rd_chk(`OFF_CONTROL, cw(3'(i), 3'(i), 1'b0, 1'b1), "control fields");
            chk("analog_src", 32'(src_exp[i]), 32'(analog_src));
        end
        wr(`OFF_CONTROL, 32'h0);
        wr(`OFF_CONTROL, 32'h2); // go while disabled is ignored
        rd_chk(`OFF_CONTROL, 32'h0, "go without enable");
        $display("test layout done");
        // every divider: duration, result, go cleared, flag and irq
        wr(`OFF_IRQ_EN, 32'h1);
        for (int k = 0; k < 6; k++) begin
            start(codes[k], 8'(8'h5A + k * 37));
            wait_irq();
            chk_rng("duration", 19 * (1 << k) - 2, 19 * (1 << k) + 5, cyc - t0);
            rd_chk(`OFF_CONTROL, cw(codes[k], 3'h0, 1'b0, 1'b1), "go cleared");
            rd_chk(`OFF_RESULT, 32'(8'(8'h5A + k * 37)), "result");
            rd_chk(`OFF_FLAGS, 32'h1, "flag set");
            wr(`OFF_FLAGS, 32'h0);
            chk("irq cleared", 32'h0, 32'(irq));
        end
        $display("test dividers done");
        // flag without irq enable, and it stays until software clears it
        wr(`OFF_IRQ_EN, 32'h0);
        start(3'h0, 8'h33);
        poll_go();
        repeat (50) @(posedge sys_clk);
        rd_chk(`OFF_FLAGS, 32'h1, "flag held");
        chk("irq masked", 32'h0, 32'(irq));
        wr(`OFF_FLAGS, 32'h0);
        $display("test flag done");
        // software abort mid-conversion: partial result, no flag
        start(3'h6, 8'hB7);
        @(negedge sys_clk);
        chk("sample phase", 32'h1, 32'(afe.sample));
        repeat (300) @(posedge sys_clk);
        wr(`OFF_CONTROL, cw(3'h6, 3'h0, 1'b0, 1'b1));
        repeat (10) @(posedge sys_clk);
        rd_chk(`OFF_RESULT, 32'hBF, "partial result");
        rd_chk(`OFF_FLAGS, 32'h0, "no flag on abort");
        $display("test abort done");
        // rc clock for both codes, start delayed by one instruction
        wr(`OFF_IRQ_EN, 32'h1);
        for (int k = 0; k < 2; k++) begin
            start(k ? 3'h7 : 3'h3, 8'hA5);
            wait_irq();
            chk_rng("rc duration", 95 + INSTR - 8, 95 + INSTR + 8, cyc - t0);
            rd_chk(`OFF_RESULT, 32'hA5, "rc result");
            wr(`OFF_FLAGS, 32'h0);
        end
        $display("test rc done");
        // sleep with rc and irq enabled: completion wakes
        start(3'h3, 8'h3C);
        sleep_req <= 1'b1;
        wait_irq();
        chk("wake", 32'h1, 32'(wake));
        sleep_req <= 1'b0;
        wr(`OFF_FLAGS, 32'h0);
        // sleep with rc and irq disabled: powers down after, enable still reads 1
        wr(`OFF_IRQ_EN, 32'h0);
        start(3'h3, 8'hC3);
        sleep_req <= 1'b1;
        repeat (40) @(posedge sys_clk);
        chk("powered in sleep", 32'h1, 32'(afe.powered));
        poll_go();
        repeat (5) @(posedge sys_clk);
        rd_chk(`OFF_RESULT, 32'hC3, "sleep result");
        chk("powered down", 32'h0, 32'(afe.powered));
        rd_chk(`OFF_CONTROL, cw(3'h3, 3'h0, 1'b0, 1'b1), "enable kept");
        sleep_req <= 1'b0;
        wr(`OFF_FLAGS, 32'h0);
        // sleep with system clock source: abort, power down, enable kept
        start(3'h6, 8'h81);
        repeat (100) @(posedge sys_clk);
        sleep_req <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk("sleep abort power", 32'h0, 32'(afe.powered));
        rd(`OFF_CONTROL, v);
        chk("sleep enable kept", 32'h1, 32'(v[0]));
        rd_chk(`OFF_FLAGS, 32'h0, "sleep abort flag");
        sleep_req <= 1'b0;
        $display("test sleep done");
        // reset in mid-conversion
        start(3'h6, 8'h18);
        repeat (100) @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk(`OFF_CONTROL, 32'h0, "control after reset");
        rd_chk(`OFF_SLEEP, 32'h0, "status after reset");
        chk("power after reset", 32'h0, 32'(afe.powered));
        rd(12'h014, v);
        chk("unmapped resp", 32'h0, 32'(last_rresp));
        chk("write resp", 32'h0, 32'(last_bresp));
        $display("test reset mid-run done");
        conclude();
    end
endmodule // tb_sar_adc_sequencer
`default_nettype wire
